/* File: common/scrr_pkg.sv */
// package of constants for the serial channel recovery and receive block
package scrr_pkg;
  localparam int unsigned CLK_MHZ = 250;
  // channel_mode_field encodings
  localparam logic [2:0] MODE_DISABLED = 3'h0;
  localparam logic [2:0] MODE_SYNC = 3'h1;
  localparam logic [2:0] MODE_TWO_WIRE = 3'h2;
  localparam logic [2:0] MODE_ASYNC7 = 3'h4;
  localparam logic [2:0] MODE_ASYNC8 = 3'h5;
  localparam logic [2:0] MODE_ASYNC9 = 3'h6;
  // serial_mode_register field positions
  localparam int unsigned MR_MODE_LSB = 0;
  localparam int unsigned MR_STOP_BIT = 4;
  localparam int unsigned MR_PARITY_ODD_BIT = 5;
  localparam int unsigned MR_PARITY_EN_BIT = 6;
  localparam int unsigned MR_RESERVED_BIT = 7;
  // reset values
  localparam logic [7:0] MR_RESET = 8'h00;
  localparam logic [15:0] BAUD_DIV_RESET = 16'h0000;
  localparam logic [8:0] RX_BUF_RESET = 9'h000;
  // data width per async mode
  localparam logic [3:0] LEN_7 = 4'h7;
  localparam logic [3:0] LEN_8 = 4'h8;
  localparam logic [3:0] LEN_9 = 4'h9;
  typedef enum logic [2:0] {
    SCRR_IDLE, SCRR_START, SCRR_DATA, SCRR_PARITY, SCRR_STOP1, SCRR_STOP2
  } scrr_rx_state_t;
endpackage : scrr_pkg

/* File: design/scrr_baud_tick.sv */
// baud tick generator: sixteen ticks per bit
`timescale 1ns/100ps
module scrr_baud_tick #(
  parameter int unsigned DIV_W = 16
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // control
  input wire logic i_run,
  input wire logic [DIV_W-1:0] i_div,
  // tick
  output logic o_tick
);
  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;
  logic tick_reg;
  logic tick_next;

  always_comb begin
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (!i_run) begin
      cnt_next = '0;
    end else if (cnt_reg >= i_div) begin
      cnt_next = '0;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (i_ce) begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign o_tick = tick_reg & i_ce;
endmodule : scrr_baud_tick

/* File: design/scrr_channel.sv */
// serial channel: mode control, async receiver and two-wire bus event requests
`timescale 1ns/100ps
// Functional notes
// - mode field zero disables channel and resets its internal circuit; receive buffer, complete flag, rts and request flag are kept.
// - mode field one selects clocked synchronous serial operation.
// - clearing tx_enable or rx_enable disables that direction, per channel.
// - receive clock starts from falling edge of the start bit.
// - line rechecked low mid start bit before data is sampled.
// - full character moves to receive buffer and sets receive complete flag.
// - request_to_send_out goes low when software reads the receive buffer.
// - pending request flag cleared by interrupt acceptance or software write.
// - two-wire mode requests on START, STOP, ACK/receive done, NACK/transmit done.
// - parity enable zero disables parity; stop select zero means one stop bit.
module scrr_channel #(
  parameter int unsigned CHANNEL = 0,
  parameter int unsigned DIV_W = 16
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // control bits from software
  input wire logic [7:0] i_serial_mode_register,
  input wire logic i_tx_enable,
  input wire logic i_rx_enable,
  input wire logic [DIV_W-1:0] i_baud_rate_divider,
  // receive buffer read and flag control
  input wire logic i_rx_buf_read,
  input wire logic i_irq_accept,
  input wire logic i_irq_flag_write,
  input wire logic i_irq_flag_wdata,
  // two-wire bus events from the bus engine
  input wire logic i_tw_start_det,
  input wire logic i_tw_stop_det,
  input wire logic i_tw_ack_or_rx_done,
  input wire logic i_tw_nack_or_tx_done,
  // line
  input wire logic i_serial_data_in,
  // status
  output logic [8:0] o_receive_buffer,
  output logic o_receive_complete_flag,
  output logic o_parity_error,
  output logic o_framing_error,
  output logic o_overrun_error,
  output logic o_request_to_send_out,
  output logic o_pending_request_flag,
  output logic o_channel_active,
  output logic o_sync_mode,
  output logic o_tx_active,
  output logic o_rx_active
);
  logic rxd_meta_reg;
  logic rxd_sync_reg;
  logic rxd_prev_reg;
  logic tick;
  logic [2:0] mode;
  logic async_mode;
  logic [3:0] char_len;

  scrr_pkg::scrr_rx_state_t st_reg;
  scrr_pkg::scrr_rx_state_t st_next;
  logic [3:0] os_reg;
  logic [3:0] os_next;
  logic [3:0] bit_reg;
  logic [3:0] bit_next;
  logic [8:0] shift_reg;
  logic [8:0] shift_next;
  logic par_reg;
  logic par_next;
  logic [8:0] buf_reg;
  logic [8:0] buf_next;
  logic full_reg;
  logic full_next;
  logic pe_reg;
  logic pe_next;
  logic fe_reg;
  logic fe_next;
  logic ore_reg;
  logic ore_next;
  logic rts_n_reg;
  logic rts_n_next;
  logic irq_reg;
  logic irq_next;

  function automatic logic [3:0] scrr_len(input logic [2:0] m);
    unique case (m)
      scrr_pkg::MODE_ASYNC7: scrr_len = scrr_pkg::LEN_7;
      scrr_pkg::MODE_ASYNC9: scrr_len = scrr_pkg::LEN_9;
      default: scrr_len = scrr_pkg::LEN_8;
    endcase
  endfunction : scrr_len

  assign mode = i_serial_mode_register[scrr_pkg::MR_MODE_LSB +: 3];
  assign async_mode = (mode == scrr_pkg::MODE_ASYNC7) || (mode == scrr_pkg::MODE_ASYNC8)
    || (mode == scrr_pkg::MODE_ASYNC9);
  assign char_len = scrr_len(mode);

  // line passes two flops before use
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
      rxd_prev_reg <= 1'b1;
    end else if (i_ce) begin
      rxd_meta_reg <= i_serial_data_in;
      rxd_sync_reg <= rxd_meta_reg;
      rxd_prev_reg <= rxd_sync_reg;
    end
  end

  scrr_baud_tick #(
    .DIV_W(DIV_W)
  ) u_tick (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_run(st_reg != scrr_pkg::SCRR_IDLE),
    .i_div(i_baud_rate_divider),
    .o_tick(tick)
  );

  always_comb begin
    st_next = st_reg;
    os_next = os_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    par_next = par_reg;
    buf_next = buf_reg;
    full_next = full_reg;
    pe_next = pe_reg;
    fe_next = fe_reg;
    ore_next = ore_reg;
    rts_n_next = rts_n_reg;
    if (i_rx_buf_read) begin
      full_next = 1'b0;
      rts_n_next = 1'b0;
    end
    if (mode == scrr_pkg::MODE_DISABLED) begin
      st_next = scrr_pkg::SCRR_IDLE;
      os_next = '0;
      bit_next = '0;
      shift_next = '0;
      pe_next = 1'b0;
      fe_next = 1'b0;
      ore_next = 1'b0;
    end else if (!i_rx_enable || !async_mode) begin
      st_next = scrr_pkg::SCRR_IDLE;
    end else begin
      unique case (st_reg)
        scrr_pkg::SCRR_IDLE: begin
          if (rxd_prev_reg && !rxd_sync_reg) begin
            st_next = scrr_pkg::SCRR_START;
            os_next = '0;
          end
        end
        scrr_pkg::SCRR_START: begin
          if (tick) begin
            os_next = os_reg + 4'h1;
            if (os_reg == 4'h7) begin
              if (rxd_sync_reg) begin
                st_next = scrr_pkg::SCRR_IDLE;
              end else begin
                st_next = scrr_pkg::SCRR_DATA;
                os_next = '0;
                bit_next = '0;
                shift_next = '0;
                par_next = 1'b0;
              end
            end
          end
        end
        default: begin
          if (tick) begin
            os_next = os_reg + 4'h1;
            if (os_reg == 4'hf) begin
              os_next = '0;
              unique case (st_reg)
                scrr_pkg::SCRR_DATA: begin
                  shift_next[bit_reg] = rxd_sync_reg;
                  par_next = par_reg ^ rxd_sync_reg;
                  bit_next = bit_reg + 4'h1;
                  if (bit_reg == char_len - 4'h1) begin
                    st_next = i_serial_mode_register[scrr_pkg::MR_PARITY_EN_BIT]
                      ? scrr_pkg::SCRR_PARITY : scrr_pkg::SCRR_STOP1;
                  end
                end
                scrr_pkg::SCRR_PARITY: begin
                  pe_next = (par_reg ^ rxd_sync_reg)
                    != i_serial_mode_register[scrr_pkg::MR_PARITY_ODD_BIT];
                  st_next = scrr_pkg::SCRR_STOP1;
                end
                scrr_pkg::SCRR_STOP1: begin
                  fe_next = !rxd_sync_reg;
                  // stop select zero gives one stop bit
                  if (i_serial_mode_register[scrr_pkg::MR_STOP_BIT] && rxd_sync_reg) begin
                    st_next = scrr_pkg::SCRR_STOP2;
                  end else begin
                    st_next = scrr_pkg::SCRR_IDLE;
                  end
                end
                default: begin
                  fe_next = !rxd_sync_reg;
                  st_next = scrr_pkg::SCRR_IDLE;
                end
              endcase
              if ((st_reg == scrr_pkg::SCRR_STOP1 && st_next == scrr_pkg::SCRR_IDLE)
                  || st_reg == scrr_pkg::SCRR_STOP2) begin
                buf_next = shift_reg;
                ore_next = full_reg && !i_rx_buf_read;
                full_next = 1'b1;
                rts_n_next = 1'b1;
              end
            end
          end
        end
      endcase
    end
  end

  always_comb begin
    irq_next = irq_reg;
    if (i_irq_accept) begin
      irq_next = 1'b0;
    end
    if (i_irq_flag_write) begin
      irq_next = i_irq_flag_wdata;
    end
    // two-wire bus events; set beats clear
    if (mode == scrr_pkg::MODE_TWO_WIRE) begin
      if (i_tw_start_det || i_tw_stop_det || i_tw_ack_or_rx_done || i_tw_nack_or_tx_done) begin
        irq_next = 1'b1;
      end
    end else if (!full_reg && full_next && mode != scrr_pkg::MODE_DISABLED) begin
      irq_next = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_reg <= scrr_pkg::SCRR_IDLE;
      os_reg <= '0;
      bit_reg <= '0;
      shift_reg <= '0;
      par_reg <= 1'b0;
      buf_reg <= scrr_pkg::RX_BUF_RESET;
      full_reg <= 1'b0;
      pe_reg <= 1'b0;
      fe_reg <= 1'b0;
      ore_reg <= 1'b0;
      rts_n_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else if (i_ce) begin
      st_reg <= st_next;
      os_reg <= os_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      par_reg <= par_next;
      buf_reg <= buf_next;
      full_reg <= full_next;
      pe_reg <= pe_next;
      fe_reg <= fe_next;
      ore_reg <= ore_next;
      rts_n_reg <= rts_n_next;
      irq_reg <= irq_next;
    end
  end

  assign o_receive_buffer = buf_reg;
  assign o_receive_complete_flag = full_reg;
  assign o_parity_error = pe_reg;
  assign o_framing_error = fe_reg;
  assign o_overrun_error = ore_reg;
  assign o_request_to_send_out = rts_n_reg;
  assign o_pending_request_flag = irq_reg;
  assign o_channel_active = (mode != scrr_pkg::MODE_DISABLED);
  assign o_sync_mode = (mode == scrr_pkg::MODE_SYNC);
  assign o_tx_active = i_tx_enable && (mode != scrr_pkg::MODE_DISABLED);
  assign o_rx_active = (st_reg != scrr_pkg::SCRR_IDLE);
endmodule : scrr_channel

/* File: bench/scrr_properties.sv */
// port checker for the serial channel
`timescale 1ns/100ps
module scrr_properties (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // control inputs
  input wire logic [7:0] i_serial_mode_register,
  input wire logic i_tx_enable,
  input wire logic i_rx_enable,
  input wire logic i_rx_buf_read,
  input wire logic i_irq_accept,
  input wire logic i_irq_flag_write,
  input wire logic i_irq_flag_wdata,
  input wire logic i_tw_start_det,
  input wire logic i_tw_stop_det,
  input wire logic i_tw_ack_or_rx_done,
  input wire logic i_tw_nack_or_tx_done,
  // watched outputs
  input wire logic o_receive_complete_flag,
  input wire logic o_parity_error,
  input wire logic o_framing_error,
  input wire logic o_overrun_error,
  input wire logic o_request_to_send_out,
  input wire logic o_pending_request_flag,
  input wire logic o_channel_active,
  input wire logic o_sync_mode,
  input wire logic o_tx_active,
  input wire logic o_rx_active
);
  logic [2:0] mode;
  logic tw_any;
  assign mode = i_serial_mode_register[2:0];
  assign tw_any = i_tw_start_det | i_tw_stop_det | i_tw_ack_or_rx_done | i_tw_nack_or_tx_done;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  rts_read_a: assert property (i_rx_buf_read && !o_rx_active |=> !o_request_to_send_out)
    else $error("rts still high after buffer read");
  off_idle_a: assert property (mode == 3'h0 |=> !o_rx_active)
    else $error("receiver busy while disabled");
  off_errs_a: assert property (mode == 3'h0 |=> !(o_parity_error || o_framing_error || o_overrun_error))
    else $error("error bit kept while disabled");
  rx_gate_a: assert property (!i_rx_enable |=> !o_rx_active)
    else $error("receiver busy with reception off");
  tx_gate_a: assert property (o_tx_active |-> i_tx_enable)
    else $error("transmitter busy with transmission off");
  sync_sel_a: assert property (o_sync_mode |-> mode == scrr_pkg::MODE_SYNC)
    else $error("sync mode without its code");
  chan_off_a: assert property (o_channel_active |-> mode != 3'h0)
    else $error("channel active while disabled");
  store_flags_a: assert property ($rose(o_receive_complete_flag) |-> o_request_to_send_out && o_pending_request_flag)
    else $error("stored character without rts or request");
  irq_clear_a: assert property ((i_irq_accept || (i_irq_flag_write && !i_irq_flag_wdata))
    && !o_rx_active && !tw_any |=> !o_pending_request_flag)
    else $error("request flag not cleared");
  tw_irq_a: assert property (mode == scrr_pkg::MODE_TWO_WIRE && tw_any |=> o_pending_request_flag)
    else $error("bus event without request");
  char_c: cover property ($rose(o_receive_complete_flag));
  overrun_c: cover property ($rose(o_overrun_error));
  tw_c: cover property (mode == scrr_pkg::MODE_TWO_WIRE && tw_any);
endmodule : scrr_properties

/* File: bench/scrr_line_model.sv */
// remote serial transmitter driving the receive line
`timescale 1ns/100ps
module scrr_line_model #(
  parameter int BIT_CLKS = 32
) (
  input wire logic i_core_clk,
  output logic o_line
);
  initial o_line = 1'b1;
  // low start bit, lsb first, one stop bit
  task automatic send(input logic [8:0] data, input int len, input bit stop_ok);
    @(negedge i_core_clk);
    o_line = 1'b0;
    repeat (BIT_CLKS) @(negedge i_core_clk);
    for (int i = 0; i < len; i++) begin
      o_line = data[i];
      repeat (BIT_CLKS) @(negedge i_core_clk);
    end
    o_line = stop_ok;
    repeat (BIT_CLKS) @(negedge i_core_clk);
    o_line = 1'b1;
    repeat (BIT_CLKS) @(negedge i_core_clk);
  endtask : send
  // noise pulse, gone before the mid start check
  task automatic glitch();
    @(negedge i_core_clk);
    o_line = 1'b0;
    repeat (6) @(negedge i_core_clk);
    o_line = 1'b1;
    repeat (4 * BIT_CLKS) @(negedge i_core_clk);
  endtask : glitch
endmodule : scrr_line_model

/* File: bench/testbench.sv */
// self-checking bench for the serial channel
`timescale 1ns/100ps
module testbench;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] mr = 8'h00;
  logic te = 1'b0, re = 1'b0, rd = 1'b0, acc = 1'b0, fw = 1'b0;
  logic [3:0] tw = 4'h0;
  wire line;
  logic [8:0] rxb, d;
  logic rcf, pe, fe, oe, rts, irq, act, syn, txa, rxa;
  int miscompares = 0, cmp_count = 0, cycles = 0;
  integer seed = 32'hfc7bce02;
  logic [2:0] modes [3] = '{scrr_pkg::MODE_ASYNC7, scrr_pkg::MODE_ASYNC8, scrr_pkg::MODE_ASYNC9};
  int lens [3] = '{7, 8, 9};
  always #2 i_core_clk = ~i_core_clk;
  scrr_line_model mdl (.i_core_clk(i_core_clk), .o_line(line));
  scrr_channel uut (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_ce(1'b1),
    .i_serial_mode_register(mr), .i_tx_enable(te), .i_rx_enable(re),
    .i_baud_rate_divider(16'h0001), .i_rx_buf_read(rd), .i_irq_accept(acc),
    .i_irq_flag_write(fw), .i_irq_flag_wdata(1'b0), .i_tw_start_det(tw[0]),
    .i_tw_stop_det(tw[1]), .i_tw_ack_or_rx_done(tw[2]), .i_tw_nack_or_tx_done(tw[3]),
    .i_serial_data_in(line), .o_receive_buffer(rxb), .o_receive_complete_flag(rcf),
    .o_parity_error(pe), .o_framing_error(fe), .o_overrun_error(oe),
    .o_request_to_send_out(rts), .o_pending_request_flag(irq), .o_channel_active(act),
    .o_sync_mode(syn), .o_tx_active(txa), .o_rx_active(rxa));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  task automatic cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask : cyc
  task automatic restart(input logic [2:0] m);
    te = 1'b0;
    re = 1'b0;
    cyc(1);
    mr = 8'h00;
    cyc(1);
    mr = {5'h00, m};
    cyc(1);
    te = 1'b1;
    re = 1'b1;
    cyc(1);
  endtask : restart
  // clear the request by acceptance or by a zero write
  task automatic clear_irq(input bit by_accept);
    acc = by_accept;
    fw = !by_accept;
    cyc(1);
    acc = 1'b0;
    fw = 1'b0;
    cyc(1);
    check(9'(irq), 9'h000);
  endtask : clear_irq
  task automatic rx_char(input int len, input bit good);
    d = 9'($random(seed)) & (9'h1ff >> (9 - len));
    mdl.send(d, len, good);
    check(rxb & (9'h1ff >> (9 - len)), d);
    check({6'h00, rcf, rts, irq}, 9'h007);
    check(9'(fe), 9'(!good));
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    cyc(1);
    check({7'h00, rcf, rts}, 9'h000);
    clear_irq(d[0]);
  endtask : rx_char
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    cyc(16);
    i_srst = 1'b0;
    cyc(1);
    check({rxb[7:0], rcf}, 9'h000);
    for (int i = 0; i < 9; i++) begin
      if (i % 3 == 0) begin
        restart(modes[i / 3]);
      end
      rx_char(lens[i / 3], 1'b1);
    end
    mdl.send(9'h05a, 8, 1'b1);
    mdl.send(9'h0c3, 8, 1'b1);
    check({rxb[7:0], oe}, 9'h187);
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    clear_irq(1'b1);
    mdl.glitch();
    check({7'h00, rcf, rxa}, 9'h000);
    re = 1'b0;
    mdl.send(9'h0a5, 8, 1'b1);
    check(9'(rcf), 9'h000);
    re = 1'b1;
    fork
      mdl.send(9'h0ff, 8, 1'b1);
      begin
        cyc(160);
        mr = 8'h00;
        cyc(2);
        check({7'h00, rxa, oe}, 9'h000);
      end
    join
    restart(scrr_pkg::MODE_ASYNC8);
    check(9'(rcf), 9'h000);
    // partial frame dropped, last stored nine-bit character kept
    check(rxb, 9'h1c3);
    rx_char(8, 1'b0);
    mr = 8'h00;
    cyc(2);
    check({5'h00, pe, fe, act, txa}, 9'h000);
    // parity on, even, two stop bits: bad parity first, then good
    mr = {1'b0, 1'b1, 1'b0, 1'b1, 1'b0, scrr_pkg::MODE_ASYNC8};
    for (int i = 0; i < 2; i++) begin
      d = 9'($random(seed)) & 9'h0ff;
      mdl.send({(^d[7:0]) ^ (i == 0), d[7:0]}, 9, 1'b1);
      check(rxb, d);
      check({7'h00, pe, fe}, {7'h00, i == 0, 1'b0});
      rd = 1'b1;
      cyc(1);
      rd = 1'b0;
    end
    clear_irq(1'b1);
    mr = {5'h00, scrr_pkg::MODE_SYNC};
    cyc(1);
    check({7'h00, syn, txa}, 9'h003);
    // bits 6 to 4 written as zero
    mr = {5'h00, scrr_pkg::MODE_TWO_WIRE};
    for (int i = 0; i < 4; i++) begin
      tw = 4'h1 << i;
      cyc(1);
      tw = 4'h0;
      cyc(1);
      check(9'(irq), 9'h001);
      clear_irq(i[0]);
    end
    conclude();
  end
endmodule : testbench
bind scrr_channel scrr_properties chk (.i_core_clk, .i_srst, .i_serial_mode_register,
  .i_tx_enable, .i_rx_enable, .i_rx_buf_read, .i_irq_accept, .i_irq_flag_write,
  .i_irq_flag_wdata, .i_tw_start_det, .i_tw_stop_det, .i_tw_ack_or_rx_done,
  .i_tw_nack_or_tx_done, .o_receive_complete_flag, .o_parity_error, .o_framing_error,
  .o_overrun_error, .o_request_to_send_out, .o_pending_request_flag, .o_channel_active,
  .o_sync_mode, .o_tx_active, .o_rx_active);
